// ===== pkg/nte_pkg.sv
/*
  Shared constants and types for the nibble transfer executor: opcode
  patterns, field positions, widths, reset values and the decoded kinds.
  Assumes a 10-bit instruction word delivered by a fetch unit on sys_clk.
*/
package nte_pkg;

  // Word and register widths
  localparam int NTE_IW = 10;            // Instruction word width
  localparam int NTE_NW = 4;             // Nibble width
  localparam int NTE_LPW = 3;            // Low pointer width
  localparam int NTE_BSW = 2;            // Bank select width
  localparam int NTE_SIW = 3;            // Stack index width
  localparam int NTE_PW = 8;             // Pair unit width

  // Fixed single-word opcodes
  localparam logic [9:0] NTE_OP_B_TO_A = 10'h01E;
  localparam logic [9:0] NTE_OP_A_TO_B = 10'h00E;
  localparam logic [9:0] NTE_OP_ROW_TO_A = 10'h01F;
  localparam logic [9:0] NTE_OP_A_TO_ROW = 10'h00C;
  localparam logic [9:0] NTE_OP_LOAD_PAIR = 10'h01A;
  localparam logic [9:0] NTE_OP_UNLOAD_PAIR = 10'h02A;
  localparam logic [9:0] NTE_OP_A_TO_LOWP = 10'h029;
  localparam logic [9:0] NTE_OP_LOWP_TO_A = 10'h051;
  localparam logic [9:0] NTE_OP_BANK_TO_A = 10'h053;
  localparam logic [9:0] NTE_OP_FILE_TO_A = 10'h052;
  localparam logic [9:0] NTE_OP_STACK_TO_A = 10'h050;
  localparam logic [9:0] NTE_OP_ROW_INC = 10'h013;
  localparam logic [9:0] NTE_OP_ROW_DEC = 10'h017;

  // Opcode prefixes of the immediate forms
  localparam logic [1:0] NTE_PFX_PAIR_IMM = 2'h3;      // Bits 9..8
  localparam logic [7:0] NTE_PFX_BANK_IMM = 8'h12;     // Bits 9..2
  localparam logic [5:0] NTE_PFX_RAM_READ = 6'h2C;     // Bits 9..4
  localparam logic [5:0] NTE_PFX_RAM_XCHG = 6'h2D;
  localparam logic [5:0] NTE_PFX_RAM_XDEC = 6'h2F;
  localparam logic [5:0] NTE_PFX_RAM_XINC = 6'h2E;
  localparam logic [5:0] NTE_PFX_RAM_WRITE = 6'h2B;

  // Field positions
  localparam int NTE_X_HI = 7;           // Immediate x field
  localparam int NTE_X_LO = 4;
  localparam int NTE_Y_HI = 3;           // Immediate y / j field
  localparam int NTE_Y_LO = 0;
  localparam int NTE_Z_HI = 1;           // Immediate z field
  localparam int NTE_Z_LO = 0;

  // Skip thresholds of the row pointer
  localparam logic [3:0] NTE_ROW_WRAP_INC = 4'h0;
  localparam logic [3:0] NTE_ROW_WRAP_DEC = 4'hF;

  // Reset values
  localparam logic [3:0] NTE_RST_NIBBLE = 4'h0;
  localparam logic [2:0] NTE_RST_LOWP = 3'h0;
  localparam logic [1:0] NTE_RST_BANK = 2'h0;
  localparam logic [7:0] NTE_RST_PAIR = 8'h00;

  // Decoded instruction kinds
  typedef enum {
    NTE_K_NONE, NTE_K_B_TO_A, NTE_K_A_TO_B, NTE_K_ROW_TO_A, NTE_K_A_TO_ROW,
    NTE_K_LOAD_PAIR, NTE_K_UNLOAD_PAIR, NTE_K_A_TO_LOWP, NTE_K_LOWP_TO_A,
    NTE_K_BANK_TO_A, NTE_K_FILE_TO_A, NTE_K_STACK_TO_A, NTE_K_PAIR_IMM,
    NTE_K_BANK_IMM, NTE_K_ROW_INC, NTE_K_ROW_DEC, NTE_K_RAM_READ,
    NTE_K_RAM_XCHG, NTE_K_RAM_XDEC, NTE_K_RAM_XINC, NTE_K_RAM_WRITE
  } nte_kind_t;

  // Instruction carrier from the fetch unit
  typedef struct packed {
    logic valid;                         // One fetched word this cycle
    logic [9:0] word;                    // Instruction word
  } nte_instr_t;

endpackage : nte_pkg

// ===== design/nte_exec.sv
/*
  Executor for the transfer group of a 4-bit core: register moves,
  pair register split moves, immediate address loads, row pointer
  stepping with skip, and RAM read, write and exchange.
  Assumes the fetch unit presents one word per cycle on sys_clk and
  that the stack index and carry writes come from logic on sys_clk.
  // Operation
  // RULE_01: Copy second_word into core_nibble fully
  // RULE_02: Copy core_nibble into second_word fully
  // RULE_03: Row pointer and core_nibble copy both ways
  // RULE_04: Pair high gets second_word, low core_nibble
  // RULE_05: Pair splits to second_word and core_nibble
  // RULE_06: Low three core bits into low_pointer
  // RULE_07: Low_pointer into low three core bits
  // RULE_08: Bank select into low two core bits
  // RULE_09: File select copied into core_nibble
  // RULE_10: Stack index into low three core bits
  // RULE_11: Pair immediate load; repeats are skipped
  // RULE_12: Bank immediate load from z field
  // RULE_13: Row increment, skip next on zero
  // RULE_14: Row decrement, skip next on fifteen
  // RULE_15: RAM ops XOR file select with j
  // RULE_16: RAM read loads core_nibble, then XOR
  // RULE_17: RAM exchange swaps, then XOR
  // RULE_18: Exchange, XOR, decrement, skip on fifteen
  // RULE_19: Exchange, XOR, increment, skip on zero
  // RULE_20: RAM write stores core_nibble, then XOR
  // RULE_21: Partial moves clear unwritten core bits
  // RULE_22: Carry untouched; skipped words change nothing
*/
`timescale 1ns/1ps

module nte_exec
  import nte_pkg::*;
#(
  parameter int RAM_DEPTH = 1024         // Nibbles of data RAM
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire nte_instr_t instr,
  input wire logic [2:0] stack_index,
  input wire logic carry_load,
  input wire logic carry_value,
  output logic [3:0] core_nibble,
  output logic [3:0] second_word,
  output logic [3:0] row_pointer,
  output logic [3:0] file_select,
  output logic [1:0] bank_select,
  output logic [2:0] low_pointer,
  output logic [7:0] pair_unit,
  output logic carry_bit,
  output logic skip_pending,
  output logic exec_done
);

  // Architectural registers
  logic [3:0] core_nibble_reg;           // Accumulator
  logic [3:0] second_word_reg;           // Second work register
  logic [3:0] row_pointer_reg;           // RAM row address
  logic [3:0] file_select_reg;           // RAM file address
  logic [1:0] bank_select_reg;           // RAM bank address
  logic [2:0] low_pointer_reg;           // Table low pointer
  logic [7:0] pair_unit_reg;             // Eight-bit pair register
  logic carry_bit_reg;                   // Carry, owned by other units
  logic skip_pending_reg;                // Next fetched word is skipped
  logic pair_chain_reg;                  // Last fetched word was a pair immediate load
  logic exec_done_reg;                   // Pulse per executed word

  // Data RAM
  logic [3:0] ram_cell [RAM_DEPTH];

  // Decode helpers
  nte_kind_t kind;
  logic run;                             // Word executes this cycle
  logic [9:0] ram_pointer;               // Bank, file and row address
  logic [3:0] ram_rd;                    // Addressed cell
  logic [3:0] imm_j;                     // j or y field
  logic [3:0] row_inc;
  logic [3:0] row_dec;

  // Opcode decode into a kind
  function automatic nte_kind_t decode(input logic [9:0] w);
    nte_kind_t k;
    k = NTE_K_NONE;
    if (w[9:8] == NTE_PFX_PAIR_IMM) begin
      k = NTE_K_PAIR_IMM;
    end else if (w[9:2] == NTE_PFX_BANK_IMM) begin
      k = NTE_K_BANK_IMM;
    end else begin
      case (w[9:4])
        NTE_PFX_RAM_READ: k = NTE_K_RAM_READ;
        NTE_PFX_RAM_XCHG: k = NTE_K_RAM_XCHG;
        NTE_PFX_RAM_XDEC: k = NTE_K_RAM_XDEC;
        NTE_PFX_RAM_XINC: k = NTE_K_RAM_XINC;
        NTE_PFX_RAM_WRITE: k = NTE_K_RAM_WRITE;
        default: begin
          case (w)
            NTE_OP_B_TO_A: k = NTE_K_B_TO_A;
            NTE_OP_A_TO_B: k = NTE_K_A_TO_B;
            NTE_OP_ROW_TO_A: k = NTE_K_ROW_TO_A;
            NTE_OP_A_TO_ROW: k = NTE_K_A_TO_ROW;
            NTE_OP_LOAD_PAIR: k = NTE_K_LOAD_PAIR;
            NTE_OP_UNLOAD_PAIR: k = NTE_K_UNLOAD_PAIR;
            NTE_OP_A_TO_LOWP: k = NTE_K_A_TO_LOWP;
            NTE_OP_LOWP_TO_A: k = NTE_K_LOWP_TO_A;
            NTE_OP_BANK_TO_A: k = NTE_K_BANK_TO_A;
            NTE_OP_FILE_TO_A: k = NTE_K_FILE_TO_A;
            NTE_OP_STACK_TO_A: k = NTE_K_STACK_TO_A;
            NTE_OP_ROW_INC: k = NTE_K_ROW_INC;
            NTE_OP_ROW_DEC: k = NTE_K_ROW_DEC;
            default: k = NTE_K_NONE;
          endcase
        end
      endcase
    end
    return k;
  endfunction : decode

  // Shared combinational terms
  always_comb begin
    kind = decode(instr.word);
    // A skip or a repeated pair load suppresses the word
    run = instr.valid && !skip_pending_reg && !(kind == NTE_K_PAIR_IMM && pair_chain_reg); // see RULE_11 RULE_22
    ram_pointer = {bank_select_reg, file_select_reg, row_pointer_reg};
    ram_rd = ram_cell[ram_pointer];
    imm_j = instr.word[NTE_Y_HI:NTE_Y_LO];
    row_inc = row_pointer_reg + 4'h1;
    row_dec = row_pointer_reg - 4'h1;
  end

  // Accumulator updates
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      core_nibble_reg <= NTE_RST_NIBBLE;
    end else if (run) begin
      case (kind)
        NTE_K_B_TO_A: core_nibble_reg <= second_word_reg; // see RULE_01
        NTE_K_ROW_TO_A: core_nibble_reg <= row_pointer_reg; // see RULE_03
        NTE_K_UNLOAD_PAIR: core_nibble_reg <= pair_unit_reg[3:0]; // see RULE_05
        NTE_K_LOWP_TO_A: core_nibble_reg <= {1'b0, low_pointer_reg}; // see RULE_07 RULE_21
        NTE_K_BANK_TO_A: core_nibble_reg <= {2'h0, bank_select_reg}; // see RULE_08 RULE_21
        NTE_K_FILE_TO_A: core_nibble_reg <= file_select_reg; // see RULE_09
        NTE_K_STACK_TO_A: core_nibble_reg <= {1'b0, stack_index}; // see RULE_10 RULE_21
        NTE_K_RAM_READ, NTE_K_RAM_XCHG, NTE_K_RAM_XDEC, NTE_K_RAM_XINC: begin
          core_nibble_reg <= ram_rd; // see RULE_16 RULE_17
        end
        default: core_nibble_reg <= core_nibble_reg;
      endcase
    end
  end

  // Second work register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      second_word_reg <= NTE_RST_NIBBLE;
    end else if (run && kind == NTE_K_A_TO_B) begin
      second_word_reg <= core_nibble_reg; // see RULE_02
    end else if (run && kind == NTE_K_UNLOAD_PAIR) begin
      second_word_reg <= pair_unit_reg[7:4]; // see RULE_05
    end
  end

  // Pair register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pair_unit_reg <= NTE_RST_PAIR;
    end else if (run && kind == NTE_K_LOAD_PAIR) begin
      pair_unit_reg <= {second_word_reg, core_nibble_reg}; // see RULE_04
    end
  end

  // Low pointer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      low_pointer_reg <= NTE_RST_LOWP;
    end else if (run && kind == NTE_K_A_TO_LOWP) begin
      low_pointer_reg <= core_nibble_reg[2:0]; // see RULE_06
    end
  end

  // Bank select
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bank_select_reg <= NTE_RST_BANK;
    end else if (run && kind == NTE_K_BANK_IMM) begin
      bank_select_reg <= instr.word[NTE_Z_HI:NTE_Z_LO]; // see RULE_12
    end
  end

  // Row pointer: moves, immediate load and stepping
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      row_pointer_reg <= NTE_RST_NIBBLE;
    end else if (run) begin
      case (kind)
        NTE_K_A_TO_ROW: row_pointer_reg <= core_nibble_reg; // see RULE_03
        NTE_K_PAIR_IMM: row_pointer_reg <= instr.word[NTE_Y_HI:NTE_Y_LO]; // see RULE_11
        NTE_K_ROW_INC, NTE_K_RAM_XINC: row_pointer_reg <= row_inc; // see RULE_13 RULE_19
        NTE_K_ROW_DEC, NTE_K_RAM_XDEC: row_pointer_reg <= row_dec; // see RULE_14 RULE_18
        default: row_pointer_reg <= row_pointer_reg;
      endcase
    end
  end

  // File select: immediate load or XOR after RAM access
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      file_select_reg <= NTE_RST_NIBBLE;
    end else if (run) begin
      case (kind)
        NTE_K_PAIR_IMM: file_select_reg <= instr.word[NTE_X_HI:NTE_X_LO]; // see RULE_11
        NTE_K_RAM_READ, NTE_K_RAM_XCHG, NTE_K_RAM_XDEC, NTE_K_RAM_XINC, NTE_K_RAM_WRITE: begin
          file_select_reg <= file_select_reg ^ imm_j; // see RULE_15
        end
        default: file_select_reg <= file_select_reg;
      endcase
    end
  end

  // RAM write side; address uses values before the XOR
  // Held off during reset so a word on the bus cannot corrupt a cell
  always_ff @(posedge sys_clk) begin
    if (run && !sys_rst) begin
      case (kind)
        NTE_K_RAM_XCHG, NTE_K_RAM_XDEC, NTE_K_RAM_XINC, NTE_K_RAM_WRITE: begin
          ram_cell[ram_pointer] <= core_nibble_reg; // see RULE_17 RULE_20
        end
        default: ;
      endcase
    end
  end

  // Skip request from row stepping
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      skip_pending_reg <= 1'b0;
    end else if (instr.valid && skip_pending_reg) begin
      skip_pending_reg <= 1'b0; // see RULE_22
    end else if (run) begin
      case (kind)
        NTE_K_ROW_INC, NTE_K_RAM_XINC: skip_pending_reg <= (row_inc == NTE_ROW_WRAP_INC); // see RULE_13 RULE_19
        NTE_K_ROW_DEC, NTE_K_RAM_XDEC: skip_pending_reg <= (row_dec == NTE_ROW_WRAP_DEC); // see RULE_14 RULE_18
        default: skip_pending_reg <= 1'b0;
      endcase
    end
  end

  // Tracks a run of pair immediate loads
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pair_chain_reg <= 1'b0;
    end else if (instr.valid) begin
      pair_chain_reg <= (kind == NTE_K_PAIR_IMM); // see RULE_11
    end
  end

  // Carry only changes by the external write port
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      carry_bit_reg <= 1'b0;
    end else if (carry_load) begin
      carry_bit_reg <= carry_value; // see RULE_22
    end
  end

  // Executed word pulse
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      exec_done_reg <= 1'b0;
    end else begin
      exec_done_reg <= run && kind != NTE_K_NONE;
    end
  end

  // Output wiring, all from flops
  assign core_nibble = core_nibble_reg;
  assign second_word = second_word_reg;
  assign row_pointer = row_pointer_reg;
  assign file_select = file_select_reg;
  assign bank_select = bank_select_reg;
  assign low_pointer = low_pointer_reg;
  assign pair_unit = pair_unit_reg;
  assign carry_bit = carry_bit_reg;
  assign skip_pending = skip_pending_reg;
  assign exec_done = exec_done_reg;

  // Checks
  property p_b_to_a;
    @(posedge sys_clk) disable iff (sys_rst)
    run && kind == NTE_K_B_TO_A |=> core_nibble_reg == $past(second_word_reg) && $stable(second_word_reg);
  endproperty
  a_b_to_a: assert property (p_b_to_a) else $error("B to A move wrong"); // see RULE_01

  property p_a_to_b;
    @(posedge sys_clk) disable iff (sys_rst)
    run && kind == NTE_K_A_TO_B |=> second_word_reg == $past(core_nibble_reg) && $stable(core_nibble_reg);
  endproperty
  a_a_to_b: assert property (p_a_to_b) else $error("A to B move wrong"); // see RULE_02

  property p_pair_load;
    @(posedge sys_clk) disable iff (sys_rst)
    run && kind == NTE_K_LOAD_PAIR |=> pair_unit_reg == {$past(second_word_reg), $past(core_nibble_reg)};
  endproperty
  a_pair_load: assert property (p_pair_load) else $error("Pair load wrong"); // see RULE_04

  property p_pair_split;
    @(posedge sys_clk) disable iff (sys_rst)
    run && kind == NTE_K_UNLOAD_PAIR |=> {second_word_reg, core_nibble_reg} == $past(pair_unit_reg);
  endproperty
  a_pair_split: assert property (p_pair_split) else $error("Pair split wrong"); // see RULE_05

  property p_partial_clear;
    @(posedge sys_clk) disable iff (sys_rst)
    run && kind == NTE_K_BANK_TO_A |=> core_nibble_reg[3:2] == 2'h0 && core_nibble_reg[1:0] == $past(bank_select_reg);
  endproperty
  a_partial_clear: assert property (p_partial_clear) else $error("Bank to A not cleared"); // see RULE_08 RULE_21

  property p_pair_repeat;
    @(posedge sys_clk) disable iff (sys_rst)
    instr.valid && kind == NTE_K_PAIR_IMM && !skip_pending_reg ##1
    instr.valid && kind == NTE_K_PAIR_IMM |=> $stable(file_select_reg) && $stable(row_pointer_reg);
  endproperty
  a_pair_repeat: assert property (p_pair_repeat) else $error("Repeated pair load executed"); // see RULE_11

  property p_inc_skip;
    @(posedge sys_clk) disable iff (sys_rst)
    run && (kind == NTE_K_ROW_INC || kind == NTE_K_RAM_XINC) |=>
    row_pointer_reg == $past(row_pointer_reg) + 4'h1 && skip_pending_reg == (row_pointer_reg == 4'h0);
  endproperty
  a_inc_skip: assert property (p_inc_skip) else $error("Row increment skip wrong"); // see RULE_13 RULE_19

  property p_dec_skip;
    @(posedge sys_clk) disable iff (sys_rst)
    run && (kind == NTE_K_ROW_DEC || kind == NTE_K_RAM_XDEC) |=>
    row_pointer_reg == $past(row_pointer_reg) - 4'h1 && skip_pending_reg == (row_pointer_reg == 4'hF);
  endproperty
  a_dec_skip: assert property (p_dec_skip) else $error("Row decrement skip wrong"); // see RULE_14 RULE_18

  property p_xor_update;
    @(posedge sys_clk) disable iff (sys_rst)
    run && (kind == NTE_K_RAM_READ || kind == NTE_K_RAM_WRITE) |=>
    file_select_reg == ($past(file_select_reg) ^ $past(imm_j));
  endproperty
  a_xor_update: assert property (p_xor_update) else $error("File select XOR wrong"); // see RULE_15

  property p_skip_quiet;
    @(posedge sys_clk) disable iff (sys_rst)
    instr.valid && skip_pending_reg |=>
    $stable(core_nibble_reg) && $stable(file_select_reg) && !skip_pending_reg && !exec_done_reg;
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) else $error("Skipped word changed state"); // see RULE_22

  property p_carry_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    !carry_load |=> $stable(carry_bit_reg);
  endproperty
  a_carry_hold: assert property (p_carry_hold) else $error("Carry changed by transfer"); // see RULE_22

endmodule : nte_exec

// ===== dv/tb_top.sv
/*
  Self-checking bench for the transfer executor: a cycle model of every
  register and of the data RAM, a RAM fill, corner cases, a random run.
  Assumes the executor takes one word per rising edge of sys_clk.
*/
`timescale 1ns/1ps

module tb_top;
  import nte_pkg::*;

  logic sys_clk = 1'b0; // 25 MHz clock
  logic sys_rst = 1'b1; // Sync reset, high
  nte_instr_t instr = '0; // Fetched word
  logic [2:0] stack_index = 3'h0; // Stack depth input
  logic carry_load = 1'b0; // Carry write strobe
  logic carry_value = 1'b0; // Carry write data
  logic [3:0] core_nibble, second_word, row_pointer, file_select;
  logic [1:0] bank_select;
  logic [2:0] low_pointer;
  logic [7:0] pair_unit;
  logic carry_bit, skip_pending, exec_done;
  // Expected state
  logic [3:0] m_a, m_b, m_row, m_file;
  logic [1:0] m_bank;
  logic [2:0] m_lowp;
  logic [7:0] m_pair;
  logic m_cy, m_skip, m_done, m_prev_pair;
  logic [3:0] m_mem [1024]; // Expected RAM
  int seed = 38558; // Fixed seed
  int fail_count = 0;
  int check_count = 0;
  bit run = 1'b0; // Comparisons enabled
  int r;
  logic [9:0] j;
  // Single-word opcodes for the random pick
  logic [9:0] fixed_ops [13] = '{NTE_OP_B_TO_A, NTE_OP_A_TO_B, NTE_OP_ROW_TO_A, NTE_OP_A_TO_ROW,
    NTE_OP_LOAD_PAIR, NTE_OP_UNLOAD_PAIR, NTE_OP_A_TO_LOWP, NTE_OP_LOWP_TO_A, NTE_OP_BANK_TO_A,
    NTE_OP_FILE_TO_A, NTE_OP_STACK_TO_A, NTE_OP_ROW_INC, NTE_OP_ROW_DEC};
  logic [5:0] ram_pfx [5] = '{NTE_PFX_RAM_READ, NTE_PFX_RAM_XCHG, NTE_PFX_RAM_XDEC,
    NTE_PFX_RAM_XINC, NTE_PFX_RAM_WRITE};

  nte_exec #(.RAM_DEPTH(1024)) u_nte_exec (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .instr(instr), .stack_index(stack_index),
    .carry_load(carry_load), .carry_value(carry_value), .core_nibble(core_nibble),
    .second_word(second_word), .row_pointer(row_pointer), .file_select(file_select),
    .bank_select(bank_select), .low_pointer(low_pointer), .pair_unit(pair_unit),
    .carry_bit(carry_bit), .skip_pending(skip_pending), .exec_done(exec_done)
  );

  // Free-running clock
  always #20 sys_clk = ~sys_clk;

  // Model of one edge, from the inputs sampled there
  task automatic model_step;
    logic [9:0] w;
    logic [9:0] addr;
    logic [3:0] t;
    logic known;
    logic ns;
    w = instr.word;
    addr = {m_bank, m_file, m_row}; // Address before this word's updates
    known = 1'b1;
    ns = 1'b0;
    m_done = 1'b0;
    if (carry_load) begin
      m_cy = carry_value; // Only the carry port moves carry
    end
    if (!instr.valid) begin
      return;
    end
    if (m_skip) begin
      m_skip = 1'b0; // Skipped word does nothing
    end else if (!(w[9:8] == NTE_PFX_PAIR_IMM && m_prev_pair)) begin
      case (w)
        NTE_OP_B_TO_A: m_a = m_b;
        NTE_OP_A_TO_B: m_b = m_a;
        NTE_OP_ROW_TO_A: m_a = m_row;
        NTE_OP_A_TO_ROW: m_row = m_a;
        NTE_OP_LOAD_PAIR: m_pair = {m_b, m_a};
        NTE_OP_UNLOAD_PAIR: {m_b, m_a} = m_pair;
        NTE_OP_A_TO_LOWP: m_lowp = m_a[2:0];
        NTE_OP_LOWP_TO_A: m_a = {1'b0, m_lowp};
        NTE_OP_BANK_TO_A: m_a = {2'b00, m_bank};
        NTE_OP_FILE_TO_A: m_a = m_file;
        NTE_OP_STACK_TO_A: m_a = {1'b0, stack_index};
        NTE_OP_ROW_INC: begin
          m_row = m_row + 4'h1;
          ns = (m_row == 4'h0);
        end
        NTE_OP_ROW_DEC: begin
          m_row = m_row - 4'h1;
          ns = (m_row == 4'hF);
        end
        default: begin
          if (w[9:8] == NTE_PFX_PAIR_IMM) begin
            {m_file, m_row} = w[7:0];
          end else if (w[9:2] == NTE_PFX_BANK_IMM) begin
            m_bank = w[1:0];
          end else if (w[9:4] == NTE_PFX_RAM_READ) begin
            m_a = m_mem[addr];
          end else if (w[9:4] == NTE_PFX_RAM_WRITE) begin
            m_mem[addr] = m_a;
          end else if (w[9:4] inside {NTE_PFX_RAM_XCHG, NTE_PFX_RAM_XDEC, NTE_PFX_RAM_XINC}) begin
            t = m_mem[addr];
            m_mem[addr] = m_a;
            m_a = t;
            if (w[9:4] == NTE_PFX_RAM_XDEC) begin
              m_row = m_row - 4'h1;
              ns = (m_row == 4'hF);
            end else if (w[9:4] == NTE_PFX_RAM_XINC) begin
              m_row = m_row + 4'h1;
              ns = (m_row == 4'h0);
            end
          end else begin
            known = 1'b0; // Unknown word
          end
          if (known && w[9:7] == 3'b101) begin
            m_file = m_file ^ w[3:0];
          end
        end
      endcase
      m_skip = ns;
      m_done = known;
    end
    m_prev_pair = (w[9:8] == NTE_PFX_PAIR_IMM); // Chain follows every valid word
  endtask : model_step

  // Model advances on the same edge as the design
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      {m_a, m_b, m_row, m_file, m_bank, m_lowp, m_pair} = '0;
      {m_cy, m_skip, m_done, m_prev_pair} = '0;
    end else begin
      model_step();
    end
  end

  // Value comparison
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_val

  // Flag comparison
  task automatic chk_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: flag got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_flag

  // Outputs are settled at the falling edge
  always @(negedge sys_clk) begin
    if (run) begin
      chk_val(8'(core_nibble), 8'(m_a));
      chk_val(8'(second_word), 8'(m_b));
      chk_val(8'(row_pointer), 8'(m_row));
      chk_val(8'(file_select), 8'(m_file));
      chk_val(8'(bank_select), 8'(m_bank));
      chk_val(8'(low_pointer), 8'(m_lowp));
      chk_val(pair_unit, m_pair);
      chk_flag(carry_bit, m_cy);
      chk_flag(skip_pending, m_skip);
      chk_flag(exec_done, m_done);
    end
  end

  // One valid word, side inputs at random
  task automatic put(input logic [9:0] w);
    @(posedge sys_clk);
    instr <= '{valid: 1'b1, word: w};
    stack_index <= 3'($random(seed));
    carry_load <= 1'($random(seed));
    carry_value <= 1'($random(seed));
  endtask : put

  // Gap cycle with a junk word
  task automatic idle;
    @(posedge sys_clk);
    instr <= '{valid: 1'b0, word: 10'($random(seed))};
  endtask : idle

  // Verdict and end of run
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // Hang guard, well past the expected 6100 cycles
  initial begin
    #(40 * 20000);
    fail_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    run = 1'b1;
    // Fill every RAM cell so reads are defined
    for (int z = 0; z < 4; z++) begin
      put({NTE_PFX_BANK_IMM, 2'(z)});
      for (int k = 0; k < 256; k++) begin
        put({NTE_PFX_PAIR_IMM, 8'(k)});
        put(NTE_OP_ROW_TO_A);
        put({NTE_PFX_RAM_WRITE, 4'h0});
      end
    end
    // Row wrap on increment, next word skipped
    put({NTE_PFX_PAIR_IMM, 8'h5F});
    put(NTE_OP_ROW_INC);
    put(NTE_OP_B_TO_A);
    // Row wrap on decrement, skip survives a gap
    put(NTE_OP_ROW_DEC);
    idle();
    put(NTE_OP_A_TO_B);
    // Pair-immediate chain across a gap
    put({NTE_PFX_PAIR_IMM, 8'h12});
    idle();
    put({NTE_PFX_PAIR_IMM, 8'h34});
    put({NTE_PFX_PAIR_IMM, 8'h56});
    put(NTE_OP_ROW_TO_A);
    // Exchange-increment at row 15, then exchange-decrement at row 0
    put({NTE_PFX_PAIR_IMM, 8'h0F});
    put({NTE_PFX_RAM_XINC, 4'h5});
    put(NTE_OP_FILE_TO_A);
    put({NTE_PFX_RAM_XDEC, 4'hA});
    put(NTE_OP_A_TO_ROW);
    // Partial moves after core holds all ones
    put({NTE_PFX_PAIR_IMM, 8'h3F});
    put(NTE_OP_ROW_TO_A);
    put(NTE_OP_STACK_TO_A);
    put(NTE_OP_ROW_TO_A);
    put(NTE_OP_BANK_TO_A);
    put(NTE_OP_ROW_TO_A);
    put(NTE_OP_LOWP_TO_A);
    put(10'h000);
    // Second reset in mid-run
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) idle();
    sys_rst <= 1'b0;
    // Random traffic with gaps and arbitrary words
    repeat (3000) begin
      r = $unsigned($random(seed)) % 24;
      j = 10'($random(seed));
      if (r < 13) begin
        put(fixed_ops[r]);
      end else if (r == 13) begin
        put({NTE_PFX_PAIR_IMM, j[7:0]});
      end else if (r == 14) begin
        put({NTE_PFX_BANK_IMM, j[1:0]});
      end else if (r < 20) begin
        put({ram_pfx[r - 15], j[3:0]});
      end else if (r < 22) begin
        put(j);
      end else begin
        idle();
      end
    end
    repeat (3) idle();
    end_sim();
  end

endmodule : tb_top
